//--- logic/csr_bank.sv
// Core special register bank with software port and hardware update ports
//
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
module csr_bank
  import csr_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic [1:0] be,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  output logic rd_err,
  input wire logic [CSR_NREG-1:0] hw_we,
  input wire logic [15:0] hw_status,
  input wire logic [15:0] hw_stack,
  input wire logic [15:0] hw_mdc,
  input wire logic [15:0] hw_gen,
  output logic [15:0] processor_status_word,
  output logic [15:0] stack_pointer,
  output logic [15:0] mdc_value,
  output logic [15:0] gen_value
);
  // ********************
  // Decode
  // ********************
  // Map an address to a one-hot register select; pointers have no slot
  function automatic logic [CSR_NREG-1:0] csr_sel(input logic [7:0] a);
    case ({a[7:1], 1'b0})
      CSR_OFF_STATUS: csr_sel = 4'h1;
      CSR_OFF_STACK: csr_sel = 4'h2;
      CSR_OFF_MDC: csr_sel = 4'h4;
      CSR_OFF_GEN: csr_sel = 4'h8;
      default: csr_sel = 4'h0;
    endcase
  endfunction

  localparam logic [15:0] MASKS [CSR_NREG] = '{CSR_MASK_STATUS, CSR_MASK_STACK, CSR_MASK_MDC, CSR_MASK_GEN};
  localparam logic [15:0] RSTS [CSR_NREG] = '{CSR_RST_STATUS, CSR_RST_STACK, CSR_RST_MDC, CSR_RST_GEN};

  logic [CSR_NREG-1:0] sel;
  logic [15:0] hw_data [CSR_NREG];
  logic [15:0] val [CSR_NREG];
  logic [1:0] be_eff;
  logic [15:0] next_rdata;

  assign sel = csr_sel(addr);
  // Zero byte enables treated as a word access
  assign be_eff = (be == 2'h0) ? CSR_BE_WORD : be;
  assign hw_data[0] = hw_status;
  assign hw_data[1] = hw_stack;
  assign hw_data[2] = hw_mdc;
  assign hw_data[3] = hw_gen;

  // ********************
  // Cells
  // ********************
  for (genvar i = 0; i < CSR_NREG; i++) begin : g_cell
    csr_cell #(
      .MASK(MASKS[i]),
      .RST(RSTS[i])
    ) u_cell (
      .clk(clk),
      .rstn(rstn),
      .sw_we(wr & sel[i]),
      .sw_be(be_eff),
      .sw_wdata(wdata),
      .hw_we(hw_we[i]),
      .hw_wdata(hw_data[i]),
      .value(val[i])
    );

    // Word write stores the masked data, even against a hardware update
    property p_sw_word;
      @(posedge clk) disable iff (!rstn)
      (wr && sel[i] && be_eff == CSR_BE_WORD) |=> (val[i] == ($past(wdata) & MASKS[i]));
    endproperty
    a_sw_word: assert property (p_sw_word) else $error("word write not stored");
  end

  assign processor_status_word = val[0];
  assign stack_pointer = val[1];
  assign mdc_value = val[2];
  assign gen_value = val[3];

  // Read mux; byte reads have no side effect, other byte shows zero
  always_comb begin
    next_rdata = 16'h0000;
    for (int i = 0; i < CSR_NREG; i++) begin
      if (sel[i]) begin
        next_rdata = val[i];
      end
    end
    if (be_eff == CSR_BE_LOW) begin
      next_rdata = {8'h00, next_rdata[7:0]};
    end else if (be_eff == CSR_BE_HIGH) begin
      next_rdata = {next_rdata[15:8], 8'h00};
    end
  end

  // Read data one cycle after the strobe; unmapped reads flag an error
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 16'h0000;
      rd_err <= 1'b0;
    end else begin
      rdata <= rd ? next_rdata : 16'h0000;
      rd_err <= rd & (sel == 4'h0);
    end
  end

  // ********************
  // Checks
  // ********************
  // Request and answer of a refused read, kept apart for reuse
  sequence s_unmapped_read;
    rd && (sel == 4'h0);
  endsequence

  sequence s_refused_answer;
    rd_err && (rdata == 16'h0000);
  endsequence

  // A read that hits a register
  sequence s_mapped_read;
    rd && (sel != 4'h0);
  endsequence

  // Software write to the status word beats its hardware update
  property p_sw_wins;
    @(posedge clk) disable iff (!rstn)
    (wr && sel[0] && be_eff == CSR_BE_WORD && hw_we[0]) |=>
      (processor_status_word == ($past(wdata) & CSR_MASK_STATUS));
  endproperty
  a_sw_wins: assert property (p_sw_wins) else $error("hardware update beat software write");

  property p_byte_clear;
    @(posedge clk) disable iff (!rstn)
    (wr && sel[1] && be_eff == CSR_BE_LOW) |=> (stack_pointer[15:8] == 8'h00);
  endproperty
  a_byte_clear: assert property (p_byte_clear) else $error("other byte not cleared");

  // High byte write to the status word clears its low byte
  property p_high_clear;
    @(posedge clk) disable iff (!rstn)
    (wr && sel[0] && be_eff == CSR_BE_HIGH) |=> (processor_status_word[7:0] == 8'h00);
  endproperty
  a_high_clear: assert property (p_high_clear) else $error("low byte not cleared");

  // Low byte write keeps the written byte, under the mask
  property p_low_store;
    @(posedge clk) disable iff (!rstn)
    (wr && sel[1] && be_eff == CSR_BE_LOW) |=>
      (stack_pointer[7:0] == ($past(wdata[7:0]) & CSR_MASK_STACK[7:0]));
  endproperty
  a_low_store: assert property (p_low_store) else $error("low byte not stored");

  // Hardware data passes the same mask, so unused bits stay clear
  property p_hw_mask;
    @(posedge clk) disable iff (!rstn)
    (hw_we[2] && !(wr && sel[2])) |=> (mdc_value == ($past(hw_mdc) & CSR_MASK_MDC));
  endproperty
  a_hw_mask: assert property (p_hw_mask) else $error("hardware update not masked");

  // Unimplemented bits stay clear whatever the source

  property p_reserved_zero;
    @(posedge clk) disable iff (!rstn)
    (mdc_value[15:8] == 8'h00) && (stack_pointer[0] == 1'b0);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

  property p_no_pointer;
    @(posedge clk) disable iff (!rstn)
    s_unmapped_read |=> s_refused_answer;
  endproperty
  a_no_pointer: assert property (p_no_pointer) else $error("unmapped read not refused");

  // A mapped read never raises the error flag
  property p_no_false_err;
    @(posedge clk) disable iff (!rstn)
    s_mapped_read |=> !rd_err;
  endproperty
  a_no_false_err: assert property (p_no_false_err) else $error("mapped read flagged");

  // A write to a hole, pointers included, changes nothing
  property p_hole_write;
    @(posedge clk) disable iff (!rstn)
    (wr && (sel == 4'h0) && (hw_we == 4'h0)) |=>
      $stable(processor_status_word) && $stable(stack_pointer) && $stable(mdc_value) && $stable(gen_value);
  endproperty
  a_hole_write: assert property (p_hole_write) else $error("unmapped write changed a register");

  // Hardware update lands when software leaves the register alone
  property p_hw_update;
    @(posedge clk) disable iff (!rstn)
    (hw_we[1] && !(wr && sel[1])) |=> (stack_pointer == ($past(hw_stack) & CSR_MASK_STACK));
  endproperty
  a_hw_update: assert property (p_hw_update) else $error("hardware update lost");

  property p_byte_read;
    @(posedge clk) disable iff (!rstn)
    (rd && sel[0] && be_eff == CSR_BE_HIGH && !wr && !hw_we[0]) |=>
      (rdata == {processor_status_word[15:8], 8'h00}) && $stable(processor_status_word);
  endproperty
  a_byte_read: assert property (p_byte_read) else $error("byte read wrong or disturbed register");

  // Status word follows the pipeline when software is quiet
  property p_hw_status;
    @(posedge clk) disable iff (!rstn)
    (hw_we[0] && !(wr && sel[0])) |=> (processor_status_word == ($past(hw_status) & CSR_MASK_STATUS));
  endproperty
  a_hw_status: assert property (p_hw_status) else $error("status update lost");

  // Low byte read shows the byte in its lane, upper lane zero
  property p_low_read;
    @(posedge clk) disable iff (!rstn)
    (rd && sel[2] && be_eff == CSR_BE_LOW) |=> (rdata == {8'h00, $past(mdc_value[7:0])});
  endproperty
  a_low_read: assert property (p_low_read) else $error("low byte read wrong");

  // Word read returns the value held at the strobe
  property p_word_read;
    @(posedge clk) disable iff (!rstn)
    (rd && sel[1] && be_eff == CSR_BE_WORD) |=> (rdata == $past(stack_pointer));
  endproperty
  a_word_read: assert property (p_word_read) else $error("word read wrong");

  // Read data stands one cycle only; idle cycles read as zero
  property p_rdata_idle;
    @(posedge clk) disable iff (!rstn)
    !rd |=> (rdata == 16'h0000) && !rd_err;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside its cycle");

  // Untouched register keeps its value, reads included
  property p_gen_hold;
    @(posedge clk) disable iff (!rstn)
    (!(wr && sel[3]) && !hw_we[3]) |=> $stable(gen_value);
  endproperty
  a_gen_hold: assert property (p_gen_hold) else $error("register changed without a write");
endmodule

//--- logic/csr_pkg.sv
// Package of constants for the core special register access block
// Notes on behaviour
// - A software write in the same cycle as a hardware update of a register wins and the hardware value is dropped.
// - A byte write stores the addressed byte and clears the other byte of the same register.
// - Unimplemented bits ignore writes and always read as zero.
// - The instruction pointer and code segment pointer are not readable or writable by register access; only branches change them.
// - Status word, stack pointer and multiply/divide control take software writes and implicit hardware updates.
// - Every register allows word and byte access, and a byte read has no side effect.
package csr_pkg;
  // ********************
  // Register map
  // ********************
  localparam logic [7:0] CSR_OFF_STATUS = 8'h00;
  localparam logic [7:0] CSR_OFF_STACK = 8'h02;
  localparam logic [7:0] CSR_OFF_MDC = 8'h04;
  localparam logic [7:0] CSR_OFF_GEN = 8'h06;
  localparam int CSR_NREG = 4;
  // Implemented bit masks
  localparam logic [15:0] CSR_MASK_STATUS = 16'hffff;
  localparam logic [15:0] CSR_MASK_STACK = 16'hfffe;
  localparam logic [15:0] CSR_MASK_MDC = 16'h00ff;
  localparam logic [15:0] CSR_MASK_GEN = 16'hffff;
  // Reset values
  localparam logic [15:0] CSR_RST_STATUS = 16'h0000;
  localparam logic [15:0] CSR_RST_STACK = 16'hfc00;
  localparam logic [15:0] CSR_RST_MDC = 16'h0000;
  localparam logic [15:0] CSR_RST_GEN = 16'h0000;
  // Byte enable encodings
  localparam logic [1:0] CSR_BE_LOW = 2'h1;
  localparam logic [1:0] CSR_BE_HIGH = 2'h2;
  localparam logic [1:0] CSR_BE_WORD = 2'h3;
endpackage

//--- logic/csr_cell.sv
// One special register cell with write merge and hardware update
`timescale 1ns/1ns
module csr_cell
  import csr_pkg::*;
#(
  parameter logic [15:0] MASK = 16'hffff,
  parameter logic [15:0] RST = 16'h0000
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic sw_we,
  input wire logic [1:0] sw_be,
  input wire logic [15:0] sw_wdata,
  input wire logic hw_we,
  input wire logic [15:0] hw_wdata,
  output logic [15:0] value
);
  logic [15:0] next_sw;

  // Byte write clears the other byte
  always_comb begin
    case (sw_be)
      CSR_BE_LOW: next_sw = {8'h00, sw_wdata[7:0]};
      CSR_BE_HIGH: next_sw = {sw_wdata[15:8], 8'h00};
      default: next_sw = sw_wdata;
    endcase
  end

  // Software first, hardware second; unimplemented bits forced to zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      value <= RST & MASK;
    end else if (sw_we) begin
      value <= next_sw & MASK;
    end else if (hw_we) begin
      value <= hw_wdata & MASK;
    end
  end
endmodule

//--- test/csr_pipe.sv
// Partner model: pipeline side issuing register accesses
`timescale 1ns/1ns
module csr_pipe (
  input wire logic clk,
  output logic [7:0] addr,
  output logic [15:0] wdata,
  output logic [1:0] be,
  output logic wr,
  output logic rd
);
  initial begin
    {addr, wdata, be, wr, rd} = '0;
  end
  // One-cycle write; reserved bits never carry a one
  task automatic put(input logic [7:0] a, input logic [15:0] d, input logic [1:0] b, input logic [15:0] m);
    addr <= a;
    wdata <= d & m;
    be <= b;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // One-cycle read; data lands in the next cycle
  task automatic get(input logic [7:0] a, input logic [1:0] b);
    addr <= a;
    be <= b;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
  endtask
endmodule

//--- test/csr_bank_bench.sv
// Testbench for the core special register bank
`timescale 1ns/1ns
module csr_bank_bench;
  import csr_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] addr;
  logic [15:0] wdata;
  logic [1:0] be;
  logic wr;
  logic rd;
  logic [15:0] rdata;
  logic rd_err;
  logic [3:0] hw_we = 4'h0;
  logic [15:0] hw_d = 16'h0000;
  logic [15:0] q [4];
  logic [15:0] mk [4] = '{CSR_MASK_STATUS, CSR_MASK_STACK, CSR_MASK_MDC, CSR_MASK_GEN};
  logic [15:0] rv [4] = '{CSR_RST_STATUS, CSR_RST_STACK, CSR_RST_MDC, CSR_RST_GEN};
  int m [4] = '{CSR_RST_STATUS, CSR_RST_STACK, CSR_RST_MDC, CSR_RST_GEN};
  logic [15:0] exp_q [$];
  logic [15:0] s = 16'h005d;
  int miscompares = 0;
  int num_checks = 0;
  int cyc = 0;
  csr_pipe u (.clk(clk), .addr(addr), .wdata(wdata), .be(be), .wr(wr), .rd(rd));
  csr_bank uut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .be(be), .wr(wr), .rd(rd),
    .rdata(rdata), .rd_err(rd_err), .hw_we(hw_we), .hw_status(hw_d), .hw_stack(hw_d), .hw_mdc(hw_d),
    .hw_gen(hw_d), .processor_status_word(q[0]), .stack_pointer(q[1]), .mdc_value(q[2]),
    .gen_value(q[3]));
  always #2 clk = ~clk;
  function automatic logic [15:0] nx(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // Lanes a read or write of this width touches
  function automatic logic [15:0] ln(input logic [1:0] b);
    return (b == 2'h1) ? 16'h00ff : (b == 2'h2) ? 16'hff00 : 16'hffff;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %h vs %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    if (miscompares == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Hang guard, far above the expected run length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      wrap_up();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    for (int k = 0; k < 4; k++) chk(q[k], m[k][15:0]);
    for (int i = 0; i < 300; i++) begin
      logic [1:0] r;
      logic [1:0] b;
      logic [3:0] h;
      logic [15:0] d;
      @(posedge clk);
      s = nx(s);
      r = s[3:2];
      b = s[1:0];
      h = s[7:4];
      s = nx(s);
      d = s;
      hw_we <= h;
      hw_d <= d;
      s = nx(s);
      u.put({5'h00, r, 1'b0}, s, b, mk[r]);
      hw_we <= 4'h0;
      // Software write beats hardware; byte write clears the other byte
      for (int k = 0; k < 4; k++) begin
        if (k == r) m[k] = s & mk[k] & ln(b);
        else if (h[k]) m[k] = d & mk[k];
      end
      #1;
      for (int k = 0; k < 4; k++) chk(q[k], m[k][15:0]);
      chk(rdata, 16'h0000);
      @(posedge clk);
      // Address bit 0 is random: the bank ignores it
      exp_q.push_back(m[s[9:8]][15:0] & ln(s[11:10]));
      u.get({5'h00, s[9:8], s[12]}, s[11:10]);
      #1;
      chk(rdata, exp_q.pop_front());
      chk({15'h0000, rd_err}, 16'h0000);
    end
    // Reset in mid-run brings every register back to its start value
    @(posedge clk);
    rstn <= 1'b0;
    #1;
    for (int k = 0; k < 4; k++) begin
      m[k] = rv[k];
      chk(q[k], m[k][15:0]);
    end
    chk(rdata, 16'h0000);
    @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    u.put(8'h08, 16'hffff, 2'h3, 16'hffff);
    u.get(8'h08, 2'h3);
    #1;
    chk(rdata, 16'h0000);
    chk({15'h0000, rd_err}, 16'h0001);
    for (int k = 0; k < 4; k++) chk(q[k], m[k][15:0]);
    wrap_up();
  end
endmodule
